/* File: inc/csl_pkg.sv */
// csl_pkg: shared constants and carrier types of the configuration source selector
// assumes a 7-bit byte-addressed host bus with byte and word access modes
package csl_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [6:0] CSL_OFF_STATUS     = 7'h04;
    localparam logic [6:0] CSL_OFF_LBA_LO     = 7'h10;
    localparam logic [6:0] CSL_OFF_LBA_HI     = 7'h12;
    localparam logic [6:0] CSL_OFF_CNT_CMD    = 7'h14;
    localparam logic [6:0] CSL_OFF_CONTROL    = 7'h18;
    localparam logic [6:0] CSL_OFF_BUF_BASE   = 7'h40;

    ////////////////////////////////////////////////////////////////////////////////
    // status word bit positions
    localparam int CSL_ST_CHAIN_LOCK  = 0;
    localparam int CSL_ST_HOST_LOCK   = 1;
    localparam int CSL_ST_BUF_READY   = 5;
    localparam int CSL_ST_CARD_READY  = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // command codes and sizes
    localparam logic [7:0] CSL_CMD_SECTOR_READ = 8'h03;
    localparam int         CSL_LBA_BITS        = 28;
    localparam int         CSL_BUF_WORDS       = 16;
    localparam int         CSL_IMG_BITS        = 3;

    ////////////////////////////////////////////////////////////////////////////////
    // control word layout, low byte at 18h, high byte at 19h
    typedef struct packed {
        logic [4:0] reserved;
        logic [2:0] image_address;
        logic       chain_controller_reset;
        logic       source_select;
        logic       config_start_request;
        logic       config_mode_select;
        logic       mode_select_override;
        logic       image_address_override;
        logic       lock_request;
        logic       lock_force_release;
    } csl_control_t;

    localparam csl_control_t CSL_CONTROL_RST = '0;

    // which interface drives the target chain
    typedef struct packed {
        logic card;
        logic host;
        logic test;
    } csl_route_t;

    localparam csl_route_t CSL_ROUTE_IDLE = '0;

    // lock arbiter states
    typedef enum logic [1:0] {
        CSL_LOCK_FREE,
        CSL_LOCK_HOST,
        CSL_LOCK_CHAIN
    } csl_lock_state_t;

endpackage

/* File: core/csl_lock_arbiter.sv */
// csl_lock_arbiter: one-owner lock on the flash card between host and chain controller
// assumes requests are levels synchronous to i_clk
`timescale 1ns/1ps
module csl_lock_arbiter
    import csl_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_host_req,
    input  wire logic i_chain_req,
    input  wire logic i_chain_hold,
    input  wire logic i_force_release,
    output logic      o_host_grant,
    output logic      o_chain_grant
);

    csl_lock_state_t state_q;

    ////////////////////////////////////////////////////////////////////////////////
    // grant held until released or forced free
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_q <= CSL_LOCK_FREE;
        end else begin
            case (state_q)
                CSL_LOCK_FREE: begin
                    if (i_host_req) begin
                        state_q <= CSL_LOCK_HOST;
                    end else if (i_chain_req && !i_chain_hold) begin
                        state_q <= CSL_LOCK_CHAIN;
                    end
                end
                CSL_LOCK_HOST: begin
                    if (!i_host_req) begin
                        state_q <= CSL_LOCK_FREE;
                    end
                end
                CSL_LOCK_CHAIN: begin
                    if (i_force_release || !i_chain_req) begin
                        state_q <= CSL_LOCK_FREE;
                    end
                end
                default: begin
                    state_q <= CSL_LOCK_FREE;
                end
            endcase
        end
    end

    // one owner at most
    assign o_host_grant  = (state_q == CSL_LOCK_HOST);
    assign o_chain_grant = (state_q == CSL_LOCK_CHAIN);

endmodule

/* File: core/csl_config_select.sv */
// csl_config_select: configuration source selection, flash card lock and sector read buffer
// assumes host bus strobes are one-cycle pulses synchronous to i_clk
//
// Function
// - register defaults select flash card as source when mode pin is 1
// - mode from pin or register bit
// - image address from pins unless overridden
// - mode override picks register mode bit
// - chain reset from reset pin or bit
// - mode1 select0: card configures after reset
// - mode0 select0 start1: card after start
// - mode1 select1 start1: host port source
// - mode1 select1: host port any start before done
// - mode1 start0 after done: test port drives chain
// - lock request bit1, granted status bit1
// - status bit0 shows chain lock held
// - chain reset bit plus force frees chain lock
// - sector address little endian, 28 bits
// - command 03h at 15h starts read
// - 16-word buffer mirrored over 40h-7Fh
// - pointer advances odd byte or word read
// - card ready at status byte 05h bit0
// - buffer ready in status bit5 and pin
`timescale 1ns/1ps
module csl_config_select
    import csl_pkg::*;
#(
    parameter int BUF_WORDS = CSL_BUF_WORDS
) (
    input  wire logic                    i_clk,
    input  wire logic                    i_sys_rst,
    input  wire logic                    i_dev_rst_pin,
    input  wire logic                    i_mode_select_pin,
    input  wire logic [CSL_IMG_BITS-1:0] i_image_address_select,
    input  wire logic [6:0]              i_mpu_addr,
    input  wire logic [15:0]             i_mpu_wdata,
    input  wire logic                    i_mpu_wr,
    input  wire logic                    i_mpu_rd,
    input  wire logic                    i_mpu_word_mode,
    output logic      [15:0]             o_mpu_rdata,
    input  wire logic                    i_chain_lock_req,
    output logic                         o_chain_lock_grant,
    input  wire logic                    i_chain_cfg_done,
    input  wire logic                    i_card_command_ready,
    output logic                         o_card_read_start,
    output logic      [CSL_LBA_BITS-1:0] o_card_lba,
    output logic      [7:0]              o_card_count,
    input  wire logic                    i_card_wvalid,
    input  wire logic [15:0]             i_card_wdata,
    output logic                         o_card_wready,
    output logic                         o_buffer_ready_pin,
    output logic                         o_chain_controller_reset,
    output logic                         o_config_mode_select,
    output logic      [CSL_IMG_BITS-1:0] o_image_address,
    output csl_route_t                   o_route
);

    localparam int PW = $clog2(BUF_WORDS);

    ////////////////////////////////////////////////////////////////////////////////
    // decode helpers
    function automatic logic is_buffer(input logic [6:0] addr);
        is_buffer = (addr[6:0] >= CSL_OFF_BUF_BASE);
    endfunction

    function automatic logic hits(input logic [6:0] addr, input logic [6:0] off);
        hits = (addr[6:1] == off[6:1]);
    endfunction

    csl_control_t           ctrl_q;
    logic [31:0]            lba_q;
    logic [15:0]            cnt_cmd_q;
    logic [15:0]            fifo_q [BUF_WORDS];
    logic [PW-1:0]          wr_ptr_q;
    logic [PW-1:0]          rd_ptr_q;
    logic [PW:0]            count_q;
    logic                   buf_ready_q;
    logic                   cfg_done_q;
    logic                   host_grant;
    logic                   chain_grant;
    logic                   wr_lo;
    logic                   wr_hi;
    logic [7:0]             d_lo;
    logic [7:0]             d_hi;
    logic                   push;
    logic                   pop;
    logic                   chain_rst;
    logic                   mode_eff;
    logic [15:0]            status_w;
    logic [15:0]            word_rd;
    csl_route_t             route_d;

    ////////////////////////////////////////////////////////////////////////////////
    // byte lane steering for byte and word mode
    assign wr_lo = i_mpu_wr && (i_mpu_word_mode || !i_mpu_addr[0]);
    assign wr_hi = i_mpu_wr && (i_mpu_word_mode || i_mpu_addr[0]);
    assign d_lo  = i_mpu_wdata[7:0];
    assign d_hi  = i_mpu_word_mode ? i_mpu_wdata[15:8] : i_mpu_wdata[7:0];

    ////////////////////////////////////////////////////////////////////////////////
    // control word
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ctrl_q <= CSL_CONTROL_RST;
        end else if (hits(i_mpu_addr, CSL_OFF_CONTROL) && !is_buffer(i_mpu_addr)) begin
            if (wr_lo) begin
                ctrl_q[7:0] <= d_lo;
            end
            if (wr_hi) begin
                ctrl_q[15:8] <= {5'h00, d_hi[2:0]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sector address, 28 bits used
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            lba_q <= 32'h0000_0000;
        end else begin
            if (hits(i_mpu_addr, CSL_OFF_LBA_LO)) begin
                if (wr_lo) begin
                    lba_q[7:0] <= d_lo;
                end
                if (wr_hi) begin
                    lba_q[15:8] <= d_hi;
                end
            end
            if (hits(i_mpu_addr, CSL_OFF_LBA_HI)) begin
                if (wr_lo) begin
                    lba_q[23:16] <= d_lo;
                end
                if (wr_hi) begin
                    lba_q[31:24] <= {4'h0, d_hi[3:0]};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sector count and command word
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            cnt_cmd_q <= 16'h0000;
        end else if (hits(i_mpu_addr, CSL_OFF_CNT_CMD)) begin
            if (wr_lo) begin
                cnt_cmd_q[7:0] <= d_lo;
            end
            if (wr_hi) begin
                cnt_cmd_q[15:8] <= d_hi;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sector read launch, one pulse per accepted command
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_card_read_start <= 1'b0;
        end else begin
            o_card_read_start <= wr_hi && hits(i_mpu_addr, CSL_OFF_CNT_CMD)
                                 && (d_hi == CSL_CMD_SECTOR_READ)
                                 && host_grant && i_card_command_ready;
        end
    end

    // card side sees the programmed address and count
    assign o_card_lba   = lba_q[CSL_LBA_BITS-1:0];
    assign o_card_count = cnt_cmd_q[7:0];

    ////////////////////////////////////////////////////////////////////////////////
    // lock arbiter
    csl_lock_arbiter u_lock (
        .i_clk           (i_clk),
        .i_sys_rst       (i_sys_rst),
        .i_host_req      (ctrl_q.lock_request),
        .i_chain_req     (i_chain_lock_req),
        .i_chain_hold    (chain_rst),
        .i_force_release (ctrl_q.chain_controller_reset && ctrl_q.lock_force_release),
        .o_host_grant    (host_grant),
        .o_chain_grant   (chain_grant)
    );

    assign o_chain_lock_grant = chain_grant;

    ////////////////////////////////////////////////////////////////////////////////
    // data buffer push and pop
    assign o_card_wready = (count_q != (PW+1)'(BUF_WORDS)) && !buf_ready_q;
    assign push          = i_card_wvalid && o_card_wready;
    assign pop           = i_mpu_rd && is_buffer(i_mpu_addr) && (count_q != '0)
                           && (i_mpu_word_mode || i_mpu_addr[0]);

    // word storage
    always_ff @(posedge i_clk) begin
        if (push) begin
            fifo_q[wr_ptr_q] <= i_card_wdata;
        end
    end

    // pointers and fill level
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            case ({push, pop})
                2'b10:   count_q <= count_q + 1'b1;
                2'b01:   count_q <= count_q - 1'b1;
                default: count_q <= count_q;
            endcase
        end
    end

    // ready from full until drained empty
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            buf_ready_q <= 1'b0;
        end else if (push && (count_q == (PW+1)'(BUF_WORDS - 1))) begin
            buf_ready_q <= 1'b1;
        end else if (pop && (count_q == (PW+1)'(1))) begin
            buf_ready_q <= 1'b0;
        end
    end

    assign o_buffer_ready_pin = buf_ready_q;

    ////////////////////////////////////////////////////////////////////////////////
    // status word
    always_comb begin
        status_w                    = 16'h0000;
        status_w[CSL_ST_CHAIN_LOCK] = chain_grant;
        status_w[CSL_ST_HOST_LOCK]  = host_grant;
        status_w[CSL_ST_BUF_READY]  = buf_ready_q;
        status_w[CSL_ST_CARD_READY] = i_card_command_ready;
    end

    // read word select, unmapped reads zero
    always_comb begin
        word_rd = 16'h0000;
        if (is_buffer(i_mpu_addr)) begin
            word_rd = fifo_q[rd_ptr_q];
        end else if (hits(i_mpu_addr, CSL_OFF_STATUS)) begin
            word_rd = status_w;
        end else if (hits(i_mpu_addr, CSL_OFF_LBA_LO)) begin
            word_rd = lba_q[15:0];
        end else if (hits(i_mpu_addr, CSL_OFF_LBA_HI)) begin
            word_rd = lba_q[31:16];
        end else if (hits(i_mpu_addr, CSL_OFF_CNT_CMD)) begin
            word_rd = cnt_cmd_q;
        end else if (hits(i_mpu_addr, CSL_OFF_CONTROL)) begin
            word_rd = ctrl_q;
        end
    end

    // registered read data, byte mode on low lane
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_mpu_rdata <= 16'h0000;
        end else if (i_mpu_rd) begin
            if (i_mpu_word_mode) begin
                o_mpu_rdata <= word_rd;
            end else begin
                o_mpu_rdata <= {8'h00, i_mpu_addr[0] ? word_rd[15:8] : word_rd[7:0]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // mode and chain reset
    assign mode_eff  = ctrl_q.mode_select_override ? ctrl_q.config_mode_select
                                                   : i_mode_select_pin;
    assign chain_rst = i_dev_rst_pin || ctrl_q.chain_controller_reset;

    // configuration finished flag, cleared by chain reset
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            cfg_done_q <= 1'b0;
        end else if (chain_rst) begin
            cfg_done_q <= 1'b0;
        end else if (i_chain_cfg_done) begin
            cfg_done_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // source selection table
    always_comb begin
        route_d = CSL_ROUTE_IDLE;
        if (chain_rst) begin
            route_d = CSL_ROUTE_IDLE;
        end else if (mode_eff) begin
            if (!ctrl_q.config_start_request && cfg_done_q) begin
                route_d.test = 1'b1;
            end else if (ctrl_q.source_select) begin
                route_d.host = 1'b1;
            end else if (!cfg_done_q) begin
                route_d.card = 1'b1;
            end
        end else if (!ctrl_q.source_select && ctrl_q.config_start_request && !cfg_done_q) begin
            route_d.card = 1'b1;
        end
    end

    // registered routing outputs
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_route                  <= CSL_ROUTE_IDLE;
            o_chain_controller_reset <= 1'b1;
            o_config_mode_select     <= 1'b0;
            o_image_address          <= '0;
        end else begin
            o_route                  <= route_d;
            o_chain_controller_reset <= chain_rst;
            o_config_mode_select     <= mode_eff;
            o_image_address          <= ctrl_q.image_address_override
                                        ? ctrl_q.image_address
                                        : i_image_address_select;
        end
    end

endmodule

/* File: tb/csl_card_model.sv */
// csl_card_model: flash card side, 256 words a sector
// assumes changes just after rising i_clk
`timescale 1ns/1ps
module csl_card_model (
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_busy,
    input  wire logic        i_slow,
    input  wire logic        i_read_start,
    input  wire logic [27:0] i_lba,
    input  wire logic [7:0]  i_count,
    input  wire logic        i_wready,
    output logic             o_command_ready,
    output logic             o_wvalid,
    output logic [15:0]      o_wdata
);
    logic [15:0] left_q;
    logic [15:0] word_q;

    // command ready unless held busy
    assign o_command_ready = !i_busy;

    // offer held until taken; data toggles while nothing is offered
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            left_q   <= 16'h0000;
            word_q   <= 16'h0000;
            o_wvalid <= 1'b0;
            o_wdata  <= 16'h0000;
        end else if (i_read_start) begin
            left_q   <= {i_count, 8'h00};
            word_q   <= i_lba[15:0];
            o_wvalid <= 1'b0;
        end else if (o_wvalid) begin
            if (i_wready) begin
                o_wvalid <= 1'b0;
                word_q   <= word_q + 16'h0001;
                left_q   <= left_q - 16'h0001;
                o_wdata  <= ~o_wdata;
            end
        end else if (left_q != 16'h0000 && (!i_slow || $urandom_range(3) == 0)) begin
            o_wvalid <= 1'b1;
            o_wdata  <= word_q;
        end else begin
            o_wdata  <= ~o_wdata;
        end
    end
endmodule

/* File: tb/csl_config_select_checker.sv */
// csl_config_select_checker: port properties
// assumes bind onto csl_config_select
`timescale 1ns/1ps
module csl_config_select_checker
    import csl_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_sys_rst,
    input wire logic        i_dev_rst_pin,
    input wire logic [6:0]  i_mpu_addr,
    input wire logic        i_mpu_rd,
    input wire logic        i_mpu_wr,
    input wire logic        i_mpu_word_mode,
    input wire logic [15:0] o_mpu_rdata,
    input wire logic        i_chain_lock_req,
    input wire logic        o_chain_lock_grant,
    input wire logic        i_card_command_ready,
    input wire logic        o_card_read_start,
    input wire logic        i_card_wvalid,
    input wire logic        o_card_wready,
    input wire logic        o_buffer_ready_pin,
    input wire logic        o_chain_controller_reset,
    input wire csl_route_t  o_route
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    ////////////////////////////////////////////////////////////
    // source routing and chain reset
    chk_route_onehot: assert property ($onehot0(o_route))
        else $error("route not one-hot");
    chk_pin_forces_reset: assert property (i_dev_rst_pin |=> o_chain_controller_reset)
        else $error("pin missed chain reset");
    chk_reset_idles: assert property (o_chain_controller_reset [*2] |-> !o_route)
        else $error("route active in chain reset");

    // sector read start
    chk_start_cause: assert property (o_card_read_start |->
        $past(i_mpu_wr && i_card_command_ready))
        else $error("start without ready write");
    chk_start_addr: assert property (o_card_read_start |-> $past(i_mpu_addr[6:1]) == 6'h0a)
        else $error("start not from command word");

    // data buffer
    chk_full_stalls: assert property (o_buffer_ready_pin |-> !o_card_wready)
        else $error("push while ready");
    chk_ready_push: assert property ($rose(o_buffer_ready_pin) |->
        $past(i_card_wvalid && o_card_wready))
        else $error("ready rose without push");
    chk_drop_read: assert property ($fell(o_buffer_ready_pin) |->
        $past(i_mpu_rd && i_mpu_addr[6]))
        else $error("ready fell without read");

    // lock
    chk_grant_req: assert property (o_chain_lock_grant |-> $past(i_chain_lock_req))
        else $error("chain grant without request");
    chk_status_lock: assert property (i_mpu_rd && i_mpu_word_mode &&
        i_mpu_addr == CSL_OFF_STATUS |=> o_mpu_rdata[0] == $past(o_chain_lock_grant))
        else $error("status bit 0 not chain grant");

    cov_start: cover property (o_card_read_start);
    cov_drain: cover property ($fell(o_buffer_ready_pin));
    cov_chain: cover property (o_chain_lock_grant);
endmodule

bind csl_config_select csl_config_select_checker u_chk (.*);

/* File: tb/csl_config_select_bench.sv */
// csl_config_select_bench: self-checking bench
// assumes card model and bound checker
`timescale 1ns/1ps
module csl_config_select_bench
    import csl_pkg::*;
;
    logic        clk = 1'b0, rst = 1'b1, dev_rst = 1'b0, mode_pin = 1'b1, rd = 1'b0;
    logic        wr = 1'b0, wmode = 1'b0, chain_req = 1'b0, cfg_done = 1'b0;
    logic        busy = 1'b0, slow = 1'b0, m, d;
    logic        wvalid, wready, cmd_ready, start, chain_grant, buf_ready, chain_rst, mode_eff;
    logic [2:0]  img_pins = 3'h0, img_eff;
    logic [6:0]  addr = 7'h00, k_list [4] = '{7'h10, 7'h12, 7'h14, 7'h18};
    logic [15:0] wdata = 16'h0000, rdata, cdata, q, r, ctl, w;
    logic [27:0] sector_address, lba_out;
    logic [31:0] lw;
    logic [7:0]  cnt_out;
    csl_route_t  route;
    int          miscompares = 0, n_checks = 0, cycles = 0, n_start = 0, k;

    csl_config_select i_dut (
        .i_clk(clk), .i_sys_rst(rst), .i_dev_rst_pin(dev_rst), .i_mode_select_pin(mode_pin),
        .i_image_address_select(img_pins), .i_mpu_addr(addr), .i_mpu_wdata(wdata),
        .i_mpu_wr(wr), .i_mpu_rd(rd), .i_mpu_word_mode(wmode), .o_mpu_rdata(rdata),
        .i_chain_lock_req(chain_req), .o_chain_lock_grant(chain_grant),
        .i_chain_cfg_done(cfg_done), .i_card_command_ready(cmd_ready),
        .o_card_read_start(start), .o_card_lba(lba_out), .o_card_count(cnt_out),
        .i_card_wvalid(wvalid), .i_card_wdata(cdata), .o_card_wready(wready),
        .o_buffer_ready_pin(buf_ready), .o_chain_controller_reset(chain_rst),
        .o_config_mode_select(mode_eff), .o_image_address(img_eff), .o_route(route)
    );

    csl_card_model i_card (
        .i_clk(clk), .i_sys_rst(rst), .i_busy(busy), .i_slow(slow), .i_read_start(start),
        .i_lba(lba_out), .i_count(cnt_out), .i_wready(wready),
        .o_command_ready(cmd_ready), .o_wvalid(wvalid), .o_wdata(cdata)
    );

    // clock, start counter and hang guard
    always #25 clk = ~clk;
    always @(negedge clk) if (start === 1'b1) n_start++;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one strobe cycle, result one cycle later
    task automatic bus(input logic wrt, wm, input logic [6:0] a, input logic [15:0] dat,
                       output logic [15:0] res);
        @(negedge clk);
        addr = a;
        wdata = dat;
        wmode = wm;
        wr = wrt;
        rd = !wrt;
        @(negedge clk);
        wr = 1'b0;
        rd = 1'b0;
        @(negedge clk);
        res = rdata;
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask

    // expected source for mode, select, start and done
    function automatic csl_route_t exp_route(input logic md, s, st, dn);
        csl_route_t e;
        e = CSL_ROUTE_IDLE;
        if (md && !st && dn) e.test = 1'b1;
        else if (md && s) e.host = 1'b1;
        else if (!dn && !s && (md || st)) e.card = 1'b1;
        return e;
    endfunction

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(19333));
        repeat (10) @(negedge clk);
        rst = 1'b0;
        idle(2);
        check("route", exp_route(1'b1, 1'b0, 1'b0, 1'b0), route);
        check("mode", 1'b1, mode_eff);
        check("image", img_pins, img_eff);
        foreach (k_list[i]) begin
            bus(1'b0, 1'b1, k_list[i], 16'h0000, q);
            check("reset", 16'h0000, q);
        end
        dev_rst = 1'b1;
        idle(2);
        check("chain reset", 1'b1, chain_rst);
        check("route", CSL_ROUTE_IDLE, route);
        dev_rst = 1'b0;
        idle(2);
        check("chain reset", 1'b0, chain_rst);
        // random selection settings
        repeat (40) begin
            ctl = 16'($urandom) & 16'h077c;
            mode_pin = 1'($urandom);
            img_pins = 3'($urandom);
            d = 1'($urandom);
            bus(1'b1, 1'b1, 7'h18, ctl | 16'h0080, q);
            bus(1'b1, 1'b1, 7'h18, ctl, q);
            cfg_done = d;
            idle(1);
            cfg_done = 1'b0;
            idle(2);
            m = ctl[3] ? ctl[4] : mode_pin;
            check("mode", m, mode_eff);
            check("image", ctl[2] ? ctl[10:8] : img_pins, img_eff);
            check("route", exp_route(m, ctl[6], ctl[5], d), route);
        end
        // lock held by chain, then forced free
        bus(1'b1, 1'b1, 7'h18, 16'h0000, q);
        chain_req = 1'b1;
        idle(3);
        bus(1'b0, 1'b1, 7'h04, 16'h0000, q);
        check("lock", 2'b01, q[1:0]);
        bus(1'b1, 1'b1, 7'h18, 16'h0002, q);
        idle(3);
        bus(1'b0, 1'b1, 7'h04, 16'h0000, q);
        check("lock", 2'b01, q[1:0]);
        bus(1'b1, 1'b1, 7'h18, 16'h0083, q);
        idle(3);
        check("chain grant", 1'b0, chain_grant);
        chain_req = 1'b0;
        bus(1'b1, 1'b1, 7'h18, 16'h0002, q);
        idle(3);
        bus(1'b0, 1'b1, 7'h04, 16'h0000, q);
        check("lock", 2'b10, q[1:0]);
        // sector address, count, refused and accepted commands
        sector_address = 28'($urandom);
        lw = {4'ha, sector_address};
        busy = 1'b1;
        for (int i = 0; i < 4; i++) bus(1'b1, 1'b0, 7'h10 + 7'(i), {8'h00, lw[8*i+:8]}, q);
        bus(1'b1, 1'b0, 7'h14, 16'h0001, q);
        bus(1'b1, 1'b0, 7'h15, 16'h0003, q);
        bus(1'b0, 1'b0, 7'h05, 16'h0000, q);
        check("card ready", 1'b0, q[0]);
        busy = 1'b0;
        bus(1'b1, 1'b0, 7'h15, 16'h0004, q);
        bus(1'b0, 1'b0, 7'h05, 16'h0000, q);
        check("card ready", 1'b1, q[0]);
        check("starts", 0, n_start);
        bus(1'b0, 1'b1, 7'h12, 16'h0000, q);
        check("address high", {4'h0, sector_address[27:16]}, q);
        check("card address", sector_address, lba_out);
        check("card count", 8'h01, cnt_out);
        bus(1'b1, 1'b0, 7'h15, 16'h0003, q);
        idle(1);
        check("starts", 1, n_start);
        bus(1'b1, 1'b1, 7'h18, 16'h0082, q);
        // drain every buffer, word and byte mode alternating
        w = sector_address[15:0];
        for (int b = 0; b < 16; b++) begin
            slow = 1'($urandom);
            k = 0;
            while (buf_ready !== 1'b1 && k < 400) begin
                idle(1);
                k++;
            end
            bus(1'b0, 1'b1, 7'h04, 16'h0000, q);
            check("ready bit", 1'b1, q[5]);
            for (int i = 0; i < 16; i++) begin
                if (b[0]) begin
                    bus(1'b0, 1'b0, 7'h40 + 7'(4 * i), 16'h0000, q);
                    bus(1'b0, 1'b0, 7'h41 + 7'(4 * i), 16'h0000, r);
                    q = {r[7:0], q[7:0]};
                end else begin
                    bus(1'b0, 1'b1, 7'h40 + 7'(2 * i), 16'h0000, q);
                end
                check("buffer word", w, q);
                w++;
            end
            idle(1);
            check("ready pin", 1'b0, buf_ready);
        end
        bus(1'b1, 1'b1, 7'h18, 16'h0000, q);
        bus(1'b0, 1'b1, 7'h04, 16'h0000, q);
        check("host grant", 1'b0, q[1]);
        bus(1'b0, 1'b1, 7'h30, 16'h0000, q);
        check("unmapped", 16'h0000, q);
        conclude();
    end
endmodule
